// ===== pus_pkg.sv
/*
  Package for the power-up and reset sequencer: states, widths and timing counts.
  Assumes a single 10 MHz clock and an external configuration store that answers reads
  with a one-cycle valid pulse.
*/
package pus_pkg;
  localparam int           ADDR_W       = 8;
  localparam int           DATA_W       = 8;
  localparam int           NUM_REGS     = 16;
  localparam int           NUM_OUTS     = 4;
  localparam logic [7:0]   LAST_ADDR    = 8'h0f;
  localparam logic [7:0]   FIRST_ADDR   = 8'h00;
  localparam logic [7:0]   ZERO_BYTE    = 8'h00;
  // settle time after the load for the other start-up tasks
  localparam int           SETTLE_NS    = 2000;
  localparam int           CLK_NS       = 100;
  localparam int           SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int           CNT_W        = 8;
  localparam logic [7:0]   SETTLE_LAST  = 8'(SETTLE_CYC - 1);
  localparam logic [7:0]   CNT_ZERO     = 8'h00;
  localparam logic [7:0]   CNT_ONE      = 8'h01;

  typedef enum logic [4:0] {
    PUS_RESET  = 5'h01,
    PUS_LOAD   = 5'h02,
    PUS_WAIT   = 5'h04,
    PUS_SETTLE = 5'h08,
    PUS_READY  = 5'h10
  } pus_state_e;
endpackage

// ===== pus_store_if.sv
/*
  Interface between the sequencer and its store reader.
  Assumes both ends sit in one clock domain.
*/
`timescale 1ns/100ps
interface pus_store_if;
  logic                      start;
  logic                      busy;
  logic                      done;
  logic                      wrEn;
  logic [pus_pkg::ADDR_W-1:0] wrAddr;
  logic [pus_pkg::DATA_W-1:0] wrData;
  modport seq (output start, input busy, input done, input wrEn, input wrAddr, input wrData);
  modport rdr (input start, output busy, output done, output wrEn, output wrAddr,
               output wrData);
endinterface

// ===== pus_store_reader.sv
/*
  Walks the configuration store from the first to the last address and hands
  each word to the register file.
  Assumes the store answers each read with storeValid some cycles later.
*/
`timescale 1ns/100ps
module pus_store_reader (
  input  wire logic                       clk,
  input  wire logic                       rst,
  pus_store_if.rdr                        sif,
  output logic                            storeRead,
  output logic [pus_pkg::ADDR_W-1:0]      storeAddr,
  input  wire logic                       storeValid,
  input  wire logic [pus_pkg::DATA_W-1:0] storeData
);
  logic                      active;
  logic                      next_active;
  logic                      pending;
  logic                      next_pending;
  logic [pus_pkg::ADDR_W-1:0] addr;
  logic [pus_pkg::ADDR_W-1:0] next_addr;
  logic                      doneQ;
  logic                      next_doneQ;
  logic                      readQ;
  logic                      next_readQ;

  always_comb begin
    next_active  = active;
    next_pending = pending;
    next_addr    = addr;
    next_doneQ   = 1'b0;
    // start always restarts the walk, so a hard reset mid-load never strands it
    if (sif.start) begin
      next_active  = 1'b1;
      next_pending = 1'b0;
      next_addr    = pus_pkg::FIRST_ADDR;
    end else if (active && !pending) begin
      next_pending = 1'b1;
    end else if (active && pending && storeValid) begin
      next_pending = 1'b0;
      if (addr == pus_pkg::LAST_ADDR) begin
        next_active = 1'b0;
        next_doneQ  = 1'b1;
      end else begin
        next_addr = addr + 8'h01;
      end
    end
    next_readQ = next_active && !next_pending;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active  <= 1'b0;
      pending <= 1'b0;
      addr    <= pus_pkg::FIRST_ADDR;
      doneQ   <= 1'b0;
      readQ   <= 1'b0;
    end else begin
      active  <= next_active;
      pending <= next_pending;
      addr    <= next_addr;
      doneQ   <= next_doneQ;
      readQ   <= next_readQ;
    end
  end

  assign storeRead  = readQ;
  assign storeAddr  = addr;
  assign sif.busy   = active;
  assign sif.done   = doneQ;
  assign sif.wrEn   = active && pending && storeValid;
  assign sif.wrAddr = addr;
  assign sif.wrData = storeData;
endmodule

// ===== pus_sequencer.sv
/*
  Power-up and reset sequencer: loads the register file from the configuration
  store, gates the host port and the clock outputs, and runs hard and soft resets.
  Assumes the host port decodes writes elsewhere and presents one-cycle strobes;
  hardResetPinN is synchronous to clk.
*/
`timescale 1ns/100ps
module pus_sequencer (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       hardResetPinN,
  input  wire logic                       hostWrEn,
  input  wire logic [pus_pkg::ADDR_W-1:0] hostWrAddr,
  input  wire logic [pus_pkg::DATA_W-1:0] hostWrData,
  input  wire logic                       hostHardResetSet,
  input  wire logic                       hostXferEnd,
  input  wire logic                       hostSoftReset,
  input  wire logic [pus_pkg::ADDR_W-1:0] hostRdAddr,
  output logic                            storeRead,
  output logic [pus_pkg::ADDR_W-1:0]      storeAddr,
  input  wire logic                       storeValid,
  input  wire logic [pus_pkg::DATA_W-1:0] storeData,
  output logic                            hostReady,
  output logic                            hostIfReset,
  output logic                            hardResetBit,
  output logic [pus_pkg::DATA_W-1:0]      hostRdData,
  output logic [pus_pkg::NUM_OUTS-1:0]    clkOutEn,
  output logic                            applyConfig,
  output logic [pus_pkg::DATA_W-1:0]      liveCfg
);
  pus_store_if sif ();

  pus_store_reader u_reader (
    .clk        (clk),
    .rst        (rst),
    .sif        (sif),
    .storeRead  (storeRead),
    .storeAddr  (storeAddr),
    .storeValid (storeValid),
    .storeData  (storeData)
  );

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  pus_pkg::pus_state_e        state;
  pus_pkg::pus_state_e        next_state;
  logic [pus_pkg::CNT_W-1:0]  cnt;
  logic [pus_pkg::CNT_W-1:0]  next_cnt;
  logic                       armed;
  logic                       next_armed;
  logic                       pinQ;
  logic                       next_pinQ;
  logic                       hardReq;
  logic                       start;
  logic                       loading;

  // pin low or a completed write of the control bit both mean the same restart
  assign hardReq = (!hardResetPinN) || (armed && hostXferEnd);
  // launching from the single load cycle keeps a stale done out of the wait state
  assign start   = (state == pus_pkg::PUS_LOAD);
  assign loading = (state == pus_pkg::PUS_LOAD) || (state == pus_pkg::PUS_WAIT);
  assign sif.start = start;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_armed = armed;
    next_pinQ  = !hardResetPinN;
    // the bit only arms; the restart waits for the end of its own transaction
    if (state == pus_pkg::PUS_READY && hostHardResetSet) begin
      next_armed = 1'b1;
    end
    case (state)
      pus_pkg::PUS_RESET: begin
        next_armed = 1'b0;
        if (hardResetPinN) begin
          next_state = pus_pkg::PUS_LOAD;
        end
      end
      pus_pkg::PUS_LOAD: begin
        next_state = pus_pkg::PUS_WAIT;
      end
      pus_pkg::PUS_WAIT: begin
        if (sif.done) begin
          next_state = pus_pkg::PUS_SETTLE;
          next_cnt   = pus_pkg::CNT_ZERO;
        end
      end
      pus_pkg::PUS_SETTLE: begin
        next_cnt = cnt + pus_pkg::CNT_ONE;
        if (cnt == pus_pkg::SETTLE_LAST) begin
          next_state = pus_pkg::PUS_READY;
        end
      end
      pus_pkg::PUS_READY: begin
        next_state = pus_pkg::PUS_READY;
      end
      default: begin
        next_state = pus_pkg::PUS_RESET;
      end
    endcase
    // a hard reset from any state restarts the full power-up sequence
    if (hardReq) begin
      next_state = pus_pkg::PUS_RESET;
      next_armed = 1'b0;
      next_cnt   = pus_pkg::CNT_ZERO;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= pus_pkg::PUS_RESET;
      cnt   <= pus_pkg::CNT_ZERO;
      armed <= 1'b0;
      pinQ  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      armed <= next_armed;
      pinQ  <= next_pinQ;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [pus_pkg::DATA_W-1:0] regs      [pus_pkg::NUM_REGS];
  logic [pus_pkg::DATA_W-1:0] next_regs [pus_pkg::NUM_REGS];
  logic                       hostOk;

  assign hostOk = (state == pus_pkg::PUS_READY) && !hardReq;

  function automatic logic hits(input logic [pus_pkg::ADDR_W-1:0] a, input int idx);
    hits = (a == pus_pkg::ADDR_W'(idx));
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < pus_pkg::NUM_REGS; gi++) begin : g_reg
      always_comb begin
        next_regs[gi] = regs[gi];
        if (sif.wrEn && hits(sif.wrAddr, gi)) begin
          next_regs[gi] = sif.wrData;
        end else if (hostOk && hostWrEn && hits(hostWrAddr, gi)) begin
          next_regs[gi] = hostWrData;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regs[gi] <= pus_pkg::ZERO_BYTE;
        end else begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  logic                        next_applyConfig;
  logic [pus_pkg::DATA_W-1:0]  next_liveCfg;
  logic [pus_pkg::NUM_OUTS-1:0] next_clkOutEn;
  logic                        readyNow;

  assign readyNow = (next_state == pus_pkg::PUS_READY);

  always_comb begin
    next_liveCfg     = liveCfg;
    // soft reset latches pending writes only, the store is never touched
    next_applyConfig = hostOk && hostSoftReset;
    if (next_applyConfig || (state == pus_pkg::PUS_SETTLE && readyNow)) begin
      next_liveCfg = next_regs[0];
    end
    next_clkOutEn = readyNow ? regs[1][pus_pkg::NUM_OUTS-1:0]
                             : {pus_pkg::NUM_OUTS{1'b0}};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hostReady    <= 1'b0;
      hostIfReset  <= 1'b1;
      hardResetBit <= 1'b0;
      hostRdData   <= pus_pkg::ZERO_BYTE;
      clkOutEn     <= {pus_pkg::NUM_OUTS{1'b0}};
      applyConfig  <= 1'b0;
      liveCfg      <= pus_pkg::ZERO_BYTE;
    end else begin
      hostReady    <= readyNow;
      hostIfReset  <= !readyNow;
      hardResetBit <= next_armed;
      hostRdData   <= readyNow ? regs[hostRdAddr[3:0]] : pus_pkg::ZERO_BYTE;
      clkOutEn     <= next_clkOutEn;
      applyConfig  <= next_applyConfig;
      liveCfg      <= next_liveCfg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_clk_gated;
    @(posedge clk) disable iff (rst) !hostReady |-> (clkOutEn == '0);
  endproperty
  a_clk_gated: assert property (p_clk_gated) else $error("clock out before init");

  property p_pin_restart;
    @(posedge clk) disable iff (rst) !hardResetPinN |=> !hostReady && hostIfReset;
  endproperty
  a_pin_restart: assert property (p_pin_restart) else $error("pin reset ignored");

  property p_bit_restart;
    @(posedge clk) disable iff (rst)
      hardResetBit && hostXferEnd |=> (state == pus_pkg::PUS_RESET) ##1 !hardResetBit;
  endproperty
  a_bit_restart: assert property (p_bit_restart) else $error("bit reset late");

  property p_reload;
    @(posedge clk) disable iff (rst)
      (state == pus_pkg::PUS_RESET) && hardResetPinN |=> loading ##1 sif.busy;
  endproperty
  a_reload: assert property (p_reload) else $error("no store reload");

  property p_init_order;
    @(posedge clk) disable iff (rst) $rose(hostReady) |-> $past(pinQ) == 1'b0;
  endproperty
  a_init_order: assert property (p_init_order) else $error("ready during pin reset");

  property p_host_gate;
    @(posedge clk) disable iff (rst) hostIfReset |-> !hostReady && (hostRdData == '0);
  endproperty
  a_host_gate: assert property (p_host_gate) else $error("host live in reset");

  property p_soft;
    @(posedge clk) disable iff (rst)
      hostOk && hostSoftReset |=> applyConfig && !storeRead && (state == pus_pkg::PUS_READY);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset wrong");

  property p_ready_after_done;
    @(posedge clk) disable iff (rst) sif.done && !hardReq |=> !hostReady [*8];
  endproperty
  a_ready_after_done: assert property (p_ready_after_done) else $error("ready too soon");
endmodule

// ===== pus_store_model.sv
/*
  Behavioural model of the nonvolatile config store.
  Assumes one read at a time, requested by a one-cycle pulse, with the
  address standing until answered.
*/
`timescale 1ns/100ps
module pus_store_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] latency,
  input  wire logic       storeRead,
  input  wire logic [7:0] storeAddr,
  output logic            storeValid,
  output logic [7:0]      storeData
);
  logic       busy;
  logic [3:0] waitCnt;
  // data toggles between answers so a stale word never passes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy       <= 1'b0;
      waitCnt    <= 4'h0;
      storeValid <= 1'b0;
      storeData  <= 8'h00;
    end else begin
      storeValid <= 1'b0;
      storeData  <= ~storeData;
      // a fresh request restarts the wait
      if (storeRead) begin
        busy    <= 1'b1;
        waitCnt <= 4'h0;
      end else if (busy) begin
        if (waitCnt >= latency) begin
          busy       <= 1'b0;
          storeValid <= 1'b1;
          storeData  <= storeAddr + 8'h30;
        end else begin
          waitCnt <= waitCnt + 4'h1;
        end
      end
    end
  end
endmodule

// ===== test_pus_sequencer.sv
/*
  Self-checking bench for the power-up and reset sequencer.
  Assumes pus_pkg and the store model are compiled first.
*/
`timescale 1ns/100ps
module test_pus_sequencer;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       hardResetPinN = 1'b1;
  logic       hostWrEn = 1'b0;
  logic [7:0] hostWrAddr = 8'h00;
  logic [7:0] hostWrData = 8'h00;
  logic       hostHardResetSet = 1'b0;
  logic       hostXferEnd = 1'b0;
  logic       hostSoftReset = 1'b0;
  logic [7:0] hostRdAddr = 8'h00;
  logic [3:0] lat = 4'h0;
  logic       storeRead, storeValid, hostReady, hostIfReset;
  logic       hardResetBit, applyConfig;
  logic [7:0] storeAddr, storeData, hostRdData, liveCfg;
  logic [3:0] clkOutEn;
  int         mismatches = 0;
  int         total_checks = 0;

  always #50 clk = ~clk;

  pus_sequencer u_dut (.clk(clk), .rst(rst), .hardResetPinN(hardResetPinN),
    .hostWrEn(hostWrEn), .hostWrAddr(hostWrAddr), .hostWrData(hostWrData),
    .hostHardResetSet(hostHardResetSet), .hostXferEnd(hostXferEnd),
    .hostSoftReset(hostSoftReset), .hostRdAddr(hostRdAddr),
    .storeRead(storeRead), .storeAddr(storeAddr), .storeValid(storeValid),
    .storeData(storeData), .hostReady(hostReady), .hostIfReset(hostIfReset),
    .hardResetBit(hardResetBit), .hostRdData(hostRdData), .clkOutEn(clkOutEn),
    .applyConfig(applyConfig), .liveCfg(liveCfg));

  pus_store_model u_store (.clk(clk), .rst(rst), .latency(lat),
    .storeRead(storeRead), .storeAddr(storeAddr), .storeValid(storeValid),
    .storeData(storeData));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // outputs must stay gated for the whole load
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (hostReady !== 1'b1 && n < 600) begin
      chk({4'h0, clkOutEn}, 8'h00, "outputs gated");
      n++;
      @(negedge clk);
    end
    chk({7'h0, hostReady}, 8'h01, "init done");
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    hostWrEn = 1'b1;
    hostWrAddr = a;
    hostWrData = d;
    @(negedge clk);
    hostWrEn = 1'b0;
    // one idle cycle so a following write never re-raises the strobe at once
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    hostRdAddr = a;
    @(negedge clk);
    chk(hostRdData, e, "read");
  endtask

  task automatic chk_held();
    chk({7'h0, hostReady}, 8'h00, "ready low");
    chk({7'h0, hostIfReset}, 8'h01, "if reset");
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_powerup();
    wr(8'h02, 8'hff);
    wait_ready();
    for (int a = 0; a < 16; a++) begin
      rd(8'(a), 8'(a) + 8'h30);
    end
    chk({4'h0, clkOutEn}, 8'h01, "enables");
  endtask

  task automatic t_soft();
    wr(8'h05, 8'h77);
    wr(8'h00, 8'ha5);
    hostSoftReset = 1'b1;
    @(negedge clk);
    hostSoftReset = 1'b0;
    chk({7'h0, applyConfig}, 8'h01, "apply");
    chk(liveCfg, 8'ha5, "live cfg");
    chk({7'h0, hostReady}, 8'h01, "no reload");
    rd(8'h05, 8'h77);
  endtask

  task automatic t_pin();
    lat = 4'h6;
    hardResetPinN = 1'b0;
    repeat (4) @(negedge clk);
    chk_held();
    chk({4'h0, clkOutEn}, 8'h00, "pin gated");
    wr(8'h05, 8'h11);
    hardResetPinN = 1'b1;
    wait_ready();
    rd(8'h05, 8'h35);
    rd(8'h00, 8'h30);
  endtask

  task automatic t_bit();
    lat = 4'h0;
    wr(8'h01, 8'h0f);
    @(negedge clk);
    chk({4'h0, clkOutEn}, 8'h0f, "enables");
    hostHardResetSet = 1'b1;
    @(negedge clk);
    hostHardResetSet = 1'b0;
    chk({7'h0, hardResetBit}, 8'h01, "bit set");
    repeat (3) @(negedge clk);
    chk({7'h0, hostReady}, 8'h01, "waits xfer end");
    hostXferEnd = 1'b1;
    @(negedge clk);
    hostXferEnd = 1'b0;
    chk_held();
    chk({7'h0, hardResetBit}, 8'h00, "bit clear");
    wait_ready();
    rd(8'h01, 8'h31);
    chk({4'h0, clkOutEn}, 8'h01, "reloaded");
    chk({7'h0, hardResetBit}, 8'h00, "bit clear");
  endtask

  initial begin
    #(5000 * 100);
    mismatches++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_powerup();
    t_soft();
    t_pin();
    t_bit();
    final_report();
  end
endmodule
